// ==== dv/usb_irq_and_test_mode_ctrl_tb.sv ====
// testbench joining processor end and device end through the port
`timescale 1ns/1ps
module usb_irq_and_test_mode_ctrl_tb;
  import usb_irq_pkg::*;
  logic clk;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] evt_tx = 5'h00;
  logic [4:1] evt_rx = 4'h0;
  logic [8:0] evt_core = 9'h000;
  logic id_pin = 1'b0, detach = 1'b0, ep0_inc = 1'b0, tp_ready = 1'b0;
  speed_t neg_speed = SPD_FS;
  speed_t speed;
  logic [5:0] ep0_idx;
  logic [7:0] ep0_byte, tp_byte;
  logic nak, dj, dk, host, dma_abort, tp_valid;
  logic dma_seen = 1'b0;
  logic [7:0] got [$];
  int compares = 0;
  int miscompares = 0;
  usb_ctl_if bus();
  // ============================================================
  // ends under test and checker
  usb_irq_cpu u_usb_irq_cpu (.CLK(clk), .SRST(srst), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .BUS(bus));
  usb_irq_dev u_usb_irq_dev (.CLK(clk), .SRST(srst), .BUS(bus),
    .EVT_TX(evt_tx), .EVT_RX(evt_rx), .EVT_CORE(evt_core),
    .ID_PIN_INPUT(id_pin), .HOST_DETACH_DETECT(detach),
    .NEG_SPEED(neg_speed), .EP0_CPU_INC(ep0_inc), .EP0_RD_IDX(ep0_idx),
    .EP0_RD_BYTE(ep0_byte), .NAK_ALL_IN(nak), .DRIVE_J(dj), .DRIVE_K(dk),
    .HOST_MODE(host), .SPEED(speed), .DMA_ABORT(dma_abort),
    .TP_BYTE(tp_byte), .TP_VALID(tp_valid), .TP_READY(tp_ready));
  usb_irq_checker u_usb_irq_checker (.CLK(clk), .SRST(srst),
    .req(bus.req), .we(bus.we), .addr(bus.addr), .wdata(bus.wdata),
    .rdata(bus.rdata), .ack(bus.ack),
    .controller_irq_line(bus.controller_irq_line));
  // endpoint 0 buffer contents as a fixed pattern of the index
  assign ep0_byte = {ep0_idx, 2'b01} ^ 8'hA5;
  // clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // packet stream capture with stalls, soft reset abort seen
  always @(posedge clk) begin
    tp_ready <= ~tp_ready;
    if (tp_valid && tp_ready) got.push_back(tp_byte);
    if (dma_abort) dma_seen <= 1'b1;
  end
  // ============================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic dev(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic [1:0] r;
    logic [31:0] s;
    axi_wr(H_OFF_ADDR, {24'h0, a}, r);
    axi_wr(H_OFF_WDATA, d, r);
    axi_wr(H_OFF_GO, {31'h0, w}, r);
    do axi_rd(H_OFF_STAT, s, r); while (s[H_ST_BUSY] || !s[H_ST_DONE]);
    axi_rd(H_OFF_RDATA, q, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    dev(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // ============================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic [1:0] r;
    logic [24:0] v;
    logic [15:0] crc;
    logic [7:0] e [56];
    logic [7:0] tmv [3];
    speed_t spx [3];
    tmv = '{8'h90, 8'hA0, 8'h80};
    spx = '{SPD_HS, SPD_FS, SPD_LS};
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_chk(OFF_MASK, 32'h0);
    rd_chk(OFF_TMODE, 32'h0);
    rd_chk(8'h3C, 32'h0);
    axi_rd(8'h40, q, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(8'h40, 32'h0, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    // every source bit: an event sets it if implemented, clear drops it
    for (int i = 0; i < SRC_W; i++) begin
      v = 25'h1 << i;
      @(posedge clk);
      evt_tx <= v[4:0]; evt_rx <= v[12:9]; evt_core <= v[24:16];
      @(posedge clk);
      evt_tx <= 5'h00; evt_rx <= 4'h0; evt_core <= 9'h000;
      rd_chk(OFF_RAW, {7'h0, v & SRC_IMPL});
      dev(1'b1, OFF_CLEAR, {7'h0, v}, q);
      rd_chk(OFF_RAW, 32'h0);
    end
    // force, mask, acknowledge and re-evaluation
    dev(1'b1, OFF_FORCE, {7'h0, SRC_IMPL}, q);
    rd_chk(OFF_RAW, {7'h0, SRC_IMPL});
    rd_chk(OFF_GATED, 32'h0);
    check({31'h0, bus.controller_irq_line}, 32'h0);
    dev(1'b1, OFF_MSET, 32'h11, q);
    rd_chk(OFF_MASK, 32'h11);
    rd_chk(OFF_GATED, 32'h11);
    check({31'h0, bus.controller_irq_line}, 32'h1);
    dev(1'b1, OFF_CLEAR, {7'h0, SRC_IMPL}, q);
    check({31'h0, bus.controller_irq_line}, 32'h1);
    dev(1'b1, OFF_ACK, 32'h0, q);
    check({31'h0, bus.controller_irq_line}, 32'h0);
    dev(1'b1, OFF_FORCE, 32'h1, q);
    dev(1'b1, OFF_ACK, 32'h0, q);
    check({31'h0, bus.controller_irq_line}, 32'h1);
    dev(1'b1, OFF_CLEAR, 32'h1, q);
    dev(1'b1, OFF_ACK, 32'h0, q);
    check({31'h0, bus.controller_irq_line}, 32'h0);
    dev(1'b1, OFF_MCLR, 32'h1, q);
    rd_chk(OFF_MASK, 32'h10);
    // line test modes
    for (int i = 0; i < 3; i++) begin
      dev(1'b1, OFF_TMODE, 32'h1 << i, q);
      check({29'h0, dk, dj, nak}, 32'h1 << i);
    end
    // forced host with the b side pin and detach both raised
    @(posedge clk);
    id_pin <= 1'b1; detach <= 1'b1;
    dev(1'b1, OFF_TMODE, 32'h0, q);
    dev(1'b1, OFF_DEV_CTL, 32'h1, q);
    check({31'h0, host}, 32'h0);
    check({30'h0, speed}, {30'h0, neg_speed});
    for (int j = 0; j < 3; j++) begin
      dev(1'b1, OFF_TMODE, {24'h0, tmv[j]}, q);
      check({31'h0, host}, 32'h1);
      check({30'h0, speed}, {30'h0, spx[j]});
    end
    rd_chk(OFF_DEV_CTL, 32'h85);
    dev(1'b1, OFF_DEV_CTL, 32'h0, q);
    check({31'h0, host}, 32'h0);
    // loopback with the processor pointer saturated
    dev(1'b1, OFF_TMODE, 32'h0, q);
    repeat (70) begin
      @(posedge clk) ep0_inc <= 1'b1;
      @(posedge clk) ep0_inc <= 1'b0;
    end
    dev(1'b1, OFF_EP0CS, 32'h2, q);
    rd_chk(OFF_EP0PTR, 32'h40);
    dev(1'b1, OFF_TMODE, 32'h40, q);
    rd_chk(OFF_EP0PTR, 32'h4000);
    rd_chk(OFF_EP0CS, 32'h1);
    rd_chk(OFF_RAW, 32'h1);
    dev(1'b1, OFF_EP0CS, 32'h40, q);
    rd_chk(OFF_EP0CS, 32'h0);
    dev(1'b1, OFF_EP0PTR, 32'h7F, q);
    rd_chk(OFF_EP0PTR, 32'h4040);
    // test packet: pid, buffer bytes, inverted crc, repeated
    crc = CRC_INIT;
    for (int i = 0; i < 53; i++) begin
      e[i + 1] = {i[5:0], 2'b01} ^ 8'hA5;
      crc = crc ^ {8'h00, e[i + 1]};
      for (int k = 0; k < 8; k++) begin
        crc = crc[0] ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
      end
    end
    e[0] = PID_DATA0;
    e[54] = ~crc[7:0];
    e[55] = ~crc[15:8];
    dev(1'b1, OFF_TMODE, 32'h8, q);
    dev(1'b1, OFF_EP0CS, 32'h2, q);
    while (got.size() < 113) @(posedge clk);
    for (int k = 0; k < 113; k++) begin
      check({24'h0, got[k]}, {24'h0, e[k % 56]});
    end
    // soft reset clears registers and aborts transfers
    dev(1'b1, OFF_CTRL, 32'h1, q);
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_TMODE, 32'h0);
    rd_chk(OFF_MASK, 32'h0);
    check({31'h0, dma_seen}, 32'h1);
    // hardware reset in mid-run
    dev(1'b1, OFF_MSET, 32'h3, q);
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd_chk(OFF_MASK, 32'h0);
    print_verdict();
  end
endmodule // usb_irq_and_test_mode_ctrl_tb

// ==== dv/usb_irq_checker.sv ====
// register port and interrupt line checks between the two ends
`timescale 1ns/1ps
module usb_irq_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // register port and interrupt line
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic controller_irq_line
);
  import usb_irq_pkg::*;
  logic [7:0] tm_r;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // ============================================================
  // helper: last test mode written, cleared by either reset
  always_ff @(posedge CLK) begin
    if (SRST || (ack && we && addr == OFF_CTRL && wdata[CTRL_RST])) begin
      tm_r <= TM_RST;
    end else if (ack && we && addr == OFF_TMODE) begin
      tm_r <= wdata[7:0];
    end
  end
  // ============================================================
  // sequences: a write or a read answered at one address
  sequence s_wr(logic [7:0] a); ack && we && addr == a; endsequence
  sequence s_rd(logic [7:0] a); ack && !we && addr == a; endsequence
  // ============================================================
  // properties
  property p_ack_next; req && !ack |=> ack; endproperty
  property p_ack_pulse; ack |=> !ack; endproperty
  property p_req_hold;
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  property p_ack_low; s_wr(OFF_ACK) |-> !controller_irq_line; endproperty
  property p_irq_hold;
    $fell(controller_irq_line) |-> (ack && we && addr == OFF_ACK) ||
      $past(ack && we && addr == OFF_CTRL);
  endproperty
  property p_raw_impl;
    s_rd(OFF_RAW) |-> ((rdata[24:0] & ~SRC_IMPL) == 25'h0) &&
      (rdata[31:25] == 7'h00);
  endproperty
  property p_no_ep0_rx; s_rd(OFF_RAW) |-> !rdata[RX_LSB]; endproperty
  property p_selfclr; s_rd(OFF_CTRL) |-> rdata[CTRL_RST] == 1'b0; endproperty
  property p_tm_back;
    s_rd(OFF_TMODE) |-> rdata == {24'h000000, tm_r};
  endproperty
  property p_unmapped;
    ack && !we && addr > OFF_EP0PTR |-> rdata == 32'h00000000;
  endproperty
  // ============================================================
  // assertions
  a_ack_next: assert property (p_ack_next)
    else $error("no answer the cycle after a request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("answer longer than one cycle");
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before its answer");
  a_ack_low: assert property (p_ack_low)
    else $error("interrupt line high after acknowledge");
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt line dropped without acknowledge");
  a_raw_impl: assert property (p_raw_impl)
    else $error("raw source shows an unused bit");
  a_no_ep0_rx: assert property (p_no_ep0_rx)
    else $error("receive source shown for endpoint 0");
  a_selfclr: assert property (p_selfclr)
    else $error("soft reset bit did not clear itself");
  a_tm_back: assert property (p_tm_back)
    else $error("test mode reads back a wrong value");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // usb_irq_checker

// ==== rtl/usb_irq_cpu.sv ====
// processor end: AXI4-Lite command registers driving the register port
`timescale 1ns/1ps
module usb_irq_cpu (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // AXI4-Lite write address and data
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // register port toward the device
  usb_ctl_if.cpu BUS
);
  import usb_irq_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] c_addr;
    logic [31:0] c_wdata;
    logic c_we;
    logic busy;
    logic done;
    logic [31:0] c_rdata;
  } cpu_state_t;

  cpu_state_t r, n;

  // byte lane merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] x;
    x = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) x[8*i +: 8] = nw[8*i +: 8];
    end
    return x;
  endfunction

  // ============================================================
  // next state
  always_comb begin
    n = r;
    if (AWVALID && AWREADY) begin
      n.aw_got = 1'b1;
      n.aw_a = AWADDR;
    end
    if (WVALID && WREADY) begin
      n.w_got = 1'b1;
      n.w_d = WDATA;
      n.w_s = WSTRB;
    end
    if (BVALID && BREADY) begin
      n.bvalid = 1'b0;
    end
    // perform a write once address and data are both held
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.aw_a)
        H_OFF_ADDR: n.c_addr = 8'(merge({24'h0, r.c_addr}, r.w_d, r.w_s));
        H_OFF_WDATA: n.c_wdata = merge(r.c_wdata, r.w_d, r.w_s);
        H_OFF_GO: begin
          // a command while one is under way is ignored
          if (!r.busy && r.w_s[0]) begin
            n.c_we = r.w_d[H_GO_WE];
            n.busy = 1'b1;
            n.done = 1'b0;
          end
        end
        H_OFF_STAT, H_OFF_RDATA: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    // device answer ends the command
    if (r.busy && BUS.ack) begin
      n.busy = 1'b0;
      n.done = 1'b1;
      n.c_rdata = BUS.rdata;
    end
    if (RVALID && RREADY) begin
      n.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (ARADDR)
        H_OFF_ADDR: n.rdata = {24'h0, r.c_addr};
        H_OFF_WDATA: n.rdata = r.c_wdata;
        H_OFF_GO: n.rdata = {31'h0, r.c_we};
        H_OFF_STAT: n.rdata = {29'h0, r.done, BUS.controller_irq_line,
                               r.busy};
        H_OFF_RDATA: n.rdata = r.c_rdata;
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // handshakes and port drive
  assign AWREADY = ~r.aw_got & ~r.bvalid;
  assign WREADY = ~r.w_got & ~r.bvalid;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = ~r.rvalid;
  assign RVALID = r.rvalid;
  assign RDATA = r.rdata;
  assign RRESP = r.rresp;
  assign BUS.req = r.busy;
  assign BUS.we = r.c_we;
  assign BUS.addr = r.c_addr;
  assign BUS.wdata = r.c_wdata;
endmodule // usb_irq_cpu

// ==== rtl/usb_irq_dev.sv ====
// device end: interrupt gathering, compliance modes, forced host, reset
//
// Contract
// - tx endpoint 4..0 interrupts, ep0 both directions
// - rx endpoint 4..1 interrupts, none for ep0
// - core bits 8..4: power, vbus, srp, detach, attach
// - core bits 3..0: sof, reset/babble, resume, suspend
// - raw source unmasked; pending source with its mask bit set interrupts processor
// - clear register clears, force register sets sources
// - mask set/clear/read, gated status readable
// - interrupt line holds until acknowledge write
// - se0 nak mode naks every in token
// - j mode drives continuous j
// - k mode drives continuous k
// - software loads packet, writes 8h, sets loaded
// - test packet repeats after single load
// - data0 pid prefix, crc suffix
// - 40h copies pointer, flags, raises ep0 interrupt
// - loopback up to 64 bytes, no session
// - 80h forces host, ignores id and detach
// - forced host follows session bit only
// - forced speed from test mode bits
// - software writes test mode after status phase
// - soft reset clears registers, aborts dma, self-clears
// - hardware reset restores all defaults
`timescale 1ns/1ps
module usb_irq_dev (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // register port and interrupt line
  usb_ctl_if.dev BUS,
  // one-cycle event strobes from the link core
  input wire logic [4:0] EVT_TX,
  input wire logic [4:1] EVT_RX,
  input wire logic [8:0] EVT_CORE,
  // transceiver pins
  input wire logic ID_PIN_INPUT,
  input wire logic HOST_DETACH_DETECT,
  // speed negotiated by the link core
  input wire usb_irq_pkg::speed_t NEG_SPEED,
  // endpoint 0 buffer
  input wire logic EP0_CPU_INC,
  output logic [5:0] EP0_RD_IDX,
  input wire logic [7:0] EP0_RD_BYTE,
  // compliance controls toward the link core
  output logic NAK_ALL_IN,
  output logic DRIVE_J,
  output logic DRIVE_K,
  output logic HOST_MODE,
  output usb_irq_pkg::speed_t SPEED,
  output logic DMA_ABORT,
  // test packet stream
  output logic [7:0] TP_BYTE,
  output logic TP_VALID,
  input wire logic TP_READY
);
  import usb_irq_pkg::*;

  typedef struct packed {
    logic [24:0] src;
    logic [24:0] mask;
    logic irq;
    logic soft_rst;
    logic [7:0] tm;
    logic session;
    logic host;
    speed_t speed;
    logic [6:0] cpu_ptr;
    logic [6:0] usb_ptr;
    logic txl;
    logic rxw;
    logic ack;
    logic [31:0] rdata;
    logic id_s1;
    logic id_s2;
    logic det_s1;
    logic det_s2;
  } dev_state_t;

  dev_state_t r, n;
  logic wr, rd, fifo_go, b_role;
  logic [24:0] ev, gated, clr, frc, mset, mclr;
  logic [7:0] a;
  logic [31:0] d;

  // ============================================================
  // decode and event gathering
  assign a = BUS.addr;
  assign d = BUS.wdata;
  assign wr = BUS.req & BUS.we & ~r.ack;
  assign rd = BUS.req & ~BUS.we & ~r.ack;
  // tx ep at 0..4, rx ep n at 8+n, core at 16..24
  assign ev = {EVT_CORE, 3'h0, EVT_RX, 4'h0, EVT_TX};
  assign clr = (wr && a == OFF_CLEAR) ? d[24:0] : '0;
  assign frc = (wr && a == OFF_FORCE) ? d[24:0] : '0;
  assign mset = (wr && a == OFF_MSET) ? d[24:0] : '0;
  assign mclr = (wr && a == OFF_MCLR) ? d[24:0] : '0;
  assign fifo_go = wr && a == OFF_TMODE && d[TM_FIFO];
  assign gated = r.src & r.mask;
  // detach level only visible in forced host, else the id level
  assign b_role = r.tm[TM_FHOST] ? r.det_s2 : r.id_s2;

  // ============================================================
  // next state
  always_comb begin
    n = r;
    n.ack = BUS.req & ~r.ack;
    n.id_s1 = ID_PIN_INPUT;
    n.id_s2 = r.id_s1;
    n.det_s1 = HOST_DETACH_DETECT;
    n.det_s2 = r.det_s1;
    // sources: set wins over a clear in the same cycle
    n.src = ((r.src & ~clr) | ev | frc) & SRC_IMPL;
    if (fifo_go) begin
      n.src[0] = 1'b1;
    end
    n.mask = ((r.mask & ~mclr) | mset) & SRC_IMPL;
    // line held until acknowledge, then drops a cycle and re-checks
    if (wr && a == OFF_ACK) begin
      n.irq = 1'b0;
    end else begin
      n.irq = r.irq | (|gated);
    end
    if (wr && a == OFF_CTRL && d[CTRL_RST]) begin
      n.soft_rst = 1'b1;
    end
    if (wr && a == OFF_TMODE) begin
      n.tm = d[7:0];
    end
    if (wr && a == OFF_DEV_CTL) begin
      n.session = d[DC_SESSION];
    end
    // endpoint 0 buffer pointer and flags
    if (EP0_CPU_INC && r.cpu_ptr < EP0_MAX) begin
      n.cpu_ptr = r.cpu_ptr + 7'h01;
    end
    if (wr && a == OFF_EP0PTR) begin
      n.cpu_ptr = (d[6:0] > EP0_MAX) ? EP0_MAX : d[6:0];
    end
    if (wr && a == OFF_EP0CS) begin
      if (d[C0_TXL]) begin
        n.txl = 1'b1;
      end
      if (d[C0_RXC]) begin
        n.rxw = 1'b0;
      end
    end
    // loopback: buffer looks flushed out and received back
    if (fifo_go) begin
      n.usb_ptr = r.cpu_ptr;
      n.cpu_ptr = 7'h00;
      n.txl = 1'b0;
      n.rxw = 1'b1;
    end
    // host role and speed
    if (r.tm[TM_FHOST]) begin
      n.host = r.session;
      if (r.tm[TM_FHS]) begin
        n.speed = SPD_HS;
      end else if (r.tm[TM_FFS]) begin
        n.speed = SPD_FS;
      end else begin
        n.speed = SPD_LS;
      end
    end else begin
      n.host = r.session & ~r.id_s2;
      n.speed = NEG_SPEED;
    end
    // read data
    if (rd) begin
      case (a)
        OFF_CTRL: n.rdata = {31'h0, r.soft_rst};
        OFF_RAW: n.rdata = {7'h0, r.src};
        OFF_MASK: n.rdata = {7'h0, r.mask};
        OFF_GATED: n.rdata = {7'h0, gated};
        OFF_TMODE: n.rdata = {24'h0, r.tm};
        OFF_DEV_CTL: n.rdata = {24'h0, b_role, 4'h0, r.host, 1'b0,
                               r.session};
        OFF_EP0CS: n.rdata = {30'h0, r.txl, r.rxw};
        OFF_EP0PTR: n.rdata = {17'h0, r.usb_ptr, 1'b0, r.cpu_ptr};
        default: n.rdata = 32'h00000000;
      endcase
    end
    // soft reset: one cycle of defaults, bit clears itself
    if (r.soft_rst) begin
      n = '0;
      n.ack = BUS.req & ~r.ack;
      n.id_s1 = ID_PIN_INPUT;
      n.id_s2 = r.id_s1;
      n.det_s1 = HOST_DETACH_DETECT;
      n.det_s2 = r.det_s1;
    end
  end

  // state register, hardware reset to defaults
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ============================================================
  // test packet sender, runs while mode set and packet loaded
  usb_test_packet_gen u_tp (
    .CLK(CLK),
    .SRST(SRST | r.soft_rst),
    .RUN(r.tm[TM_PKT] & r.txl),
    .RD_IDX(EP0_RD_IDX),
    .RD_BYTE(EP0_RD_BYTE),
    .TX_BYTE(TP_BYTE),
    .TX_VALID(TP_VALID),
    .TX_READY(TP_READY)
  );

  // outputs
  assign BUS.ack = r.ack;
  assign BUS.rdata = r.rdata;
  assign BUS.controller_irq_line = r.irq;
  assign NAK_ALL_IN = r.tm[TM_SE0NAK];
  assign DRIVE_J = r.tm[TM_J];
  assign DRIVE_K = r.tm[TM_K];
  assign HOST_MODE = r.host;
  assign SPEED = r.speed;
  assign DMA_ABORT = r.soft_rst;
endmodule // usb_irq_dev

// ==== rtl/usb_test_packet_gen.sv ====
// repeating test packet sender: data0 pid, buffered bytes, crc16
`timescale 1ns/1ps
module usb_test_packet_gen (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // level that keeps the packet going
  input wire logic RUN,
  // endpoint 0 buffer read port
  output logic [5:0] RD_IDX,
  input wire logic [7:0] RD_BYTE,
  // byte stream
  output logic [7:0] TX_BYTE,
  output logic TX_VALID,
  input wire logic TX_READY
);
  import usb_irq_pkg::*;

  typedef struct packed {
    tp_phase_t phase;
    logic [5:0] idx;
    logic [15:0] crc;
    logic [7:0] byte_v;
    logic valid;
  } tp_state_t;

  tp_state_t r, n;

  // bytewise crc16, reflected polynomial
  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // ============================================================
  // sequencer: advance whenever the slot is empty or taken
  always_comb begin
    n = r;
    if (!RUN) begin
      n.phase = TP_IDLE;
      n.valid = 1'b0;
    end else if (!r.valid || TX_READY) begin
      n.valid = 1'b1;
      case (r.phase)
        TP_IDLE, TP_CRC_HI: begin
          n.byte_v = PID_DATA0;
          n.crc = CRC_INIT;
          n.idx = 6'h00;
          n.phase = TP_PID;
        end
        TP_PID, TP_DATA: begin
          if (r.idx == TP_LEN) begin
            n.byte_v = ~r.crc[7:0];
            n.phase = TP_CRC_LO;
          end else begin
            n.byte_v = RD_BYTE;
            n.crc = crc_upd(r.crc, RD_BYTE);
            n.idx = r.idx + 6'h01;
            n.phase = TP_DATA;
          end
        end
        TP_CRC_LO: begin
          n.byte_v = ~r.crc[15:8];
          n.phase = TP_CRC_HI;
        end
        default: n.phase = TP_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign RD_IDX = r.idx;
  assign TX_BYTE = r.byte_v;
  assign TX_VALID = r.valid;
endmodule // usb_test_packet_gen

// ==== shared/usb_ctl_if.sv ====
// register port and interrupt line between processor agent and device
`timescale 1ns/1ps
interface usb_ctl_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic controller_irq_line;
  modport dev (input req, we, addr, wdata,
               output rdata, ack, controller_irq_line);
  modport cpu (output req, we, addr, wdata,
               input rdata, ack, controller_irq_line);
endinterface

// ==== shared/usb_irq_pkg.sv ====
// constants and types shared by both ends of the interrupt and test block
package usb_irq_pkg;
  // ============================================================
  // device register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RAW = 8'h04;
  localparam logic [7:0] OFF_FORCE = 8'h08;
  localparam logic [7:0] OFF_CLEAR = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_MSET = 8'h14;
  localparam logic [7:0] OFF_MCLR = 8'h18;
  localparam logic [7:0] OFF_GATED = 8'h1C;
  localparam logic [7:0] OFF_ACK = 8'h20;
  localparam logic [7:0] OFF_TMODE = 8'h24;
  localparam logic [7:0] OFF_DEV_CTL = 8'h28;
  localparam logic [7:0] OFF_EP0CS = 8'h2C;
  localparam logic [7:0] OFF_EP0PTR = 8'h30;
  // ============================================================
  // interrupt source layout
  localparam int SRC_W = 25;
  localparam int RX_LSB = 8;
  localparam int CORE_LSB = 16;
  localparam logic [24:0] SRC_IMPL = 25'h1FF1E1F;
  localparam logic [24:0] SRC_RST = 25'h0000000;
  localparam logic [24:0] MASK_RST = 25'h0000000;
  // ============================================================
  // field positions
  localparam int CTRL_RST = 0;
  localparam int TM_SE0NAK = 0;
  localparam int TM_J = 1;
  localparam int TM_K = 2;
  localparam int TM_PKT = 3;
  localparam int TM_FHS = 4;
  localparam int TM_FFS = 5;
  localparam int TM_FIFO = 6;
  localparam int TM_FHOST = 7;
  localparam logic [7:0] TM_RST = 8'h00;
  localparam int DC_SESSION = 0;
  localparam int DC_HOST = 2;
  localparam int DC_BROLE = 7;
  localparam int C0_RXW = 0;
  localparam int C0_TXL = 1;
  localparam int C0_RXC = 6;
  localparam int PTR_USB_LSB = 8;
  // ============================================================
  // endpoint 0 buffer and test packet
  localparam logic [6:0] EP0_MAX = 7'h40;
  localparam logic [5:0] TP_LEN = 6'h35;
  localparam logic [7:0] PID_DATA0 = 8'hC3;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  typedef enum logic [1:0] {SPD_HS, SPD_FS, SPD_LS} speed_t;
  typedef enum {TP_IDLE, TP_PID, TP_DATA, TP_CRC_LO, TP_CRC_HI} tp_phase_t;
  // ============================================================
  // processor agent registers (AXI4-Lite side)
  localparam logic [7:0] H_OFF_ADDR = 8'h00;
  localparam logic [7:0] H_OFF_WDATA = 8'h04;
  localparam logic [7:0] H_OFF_GO = 8'h08;
  localparam logic [7:0] H_OFF_STAT = 8'h0C;
  localparam logic [7:0] H_OFF_RDATA = 8'h10;
  localparam int H_GO_WE = 0;
  localparam int H_ST_BUSY = 0;
  localparam int H_ST_IRQ = 1;
  localparam int H_ST_DONE = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
